// ==== inc/ptb_defines.svh ====
// register map, field positions, reset values and trigger write mask of the pwm time base
// assumes inclusion by bare name from design and bench files
`ifndef PTB_DEFINES_SVH
`define PTB_DEFINES_SVH

`define PTB_ADDR_W        4
`define PTB_DATA_W        8
`define PTB_IDX_CTRL0     4'h0
`define PTB_IDX_CTRL1     4'h1
`define PTB_IDX_TRIGUPD   4'h2
`define PTB_IDX_TMR_LO    4'h3
`define PTB_IDX_TMR_HI    4'h4
`define PTB_IDX_PER_LO    4'h5
`define PTB_IDX_PER_HI    4'h6
`define PTB_IDX_INTSTAT   4'h7

`define PTB_CTRL0_RESET   8'h00
`define PTB_CTRL0_MODE_LO 0
`define PTB_CTRL0_PRE_LO  2
`define PTB_CTRL0_POST_LO 4
`define PTB_CTRL1_EN_BIT  7
`define PTB_CTRL1_DIR_BIT 6
`define PTB_TRIG_RESET    8'h00
`define PTB_TRIG_SYNC_BIT 0
`define PTB_TRIG_BUFFER_UPDATE_DISABLE_BIT 1
`define PTB_TRIG_DIR_BIT  3
`define PTB_TRIG_POST_LO  4
`define PTB_TRIG_MASK     8'hfb
`define PTB_INT_FLAG_BIT  0

`endif

// ==== inc/ptb_pkg.sv ====
// types shared by the pwm time base and its bench
// assumes nothing beyond a systemverilog compiler
package ptb_pkg;
	typedef enum logic [1:0] {
		PTB_FREE_RUN   = 2'h0,
		PTB_SINGLE     = 2'h1,
		PTB_UPDOWN     = 2'h2,
		PTB_UPDOWN_DBL = 2'h3
	} ptb_mode_e;
endpackage

// ==== hdl/ptb_time_base.sv ====
// twelve-bit pwm time base with prescaler, postscaler, double-buffered period
// assumes a register master on sys_clk and compare/override logic outside
// Summary of operation
// - four-bit trigger postscale field selects 1:1 to 1:16
// - trigger direction bit picks down-count (set) or up-count (clear) triggering
// - update-disable bit blocks every buffer-to-active transfer
// - override-sync bit defers overrides to the time base boundary
// - free-running: count up to period, then zero, repeat while enabled
// - single-shot: count up, zero after match, hardware clears enable
// - up/down: count up to period, then down, then up at zero
// - read-only status bit shows one while counting down
// - up/down: compare outputs gated off until first down count
// - prescaler divides instruction clock by 1, 4, 16 or 64
// - timer or control writes and reset clear the prescaler; control writes keep the timer
// - four-bit postscaler divides events, cleared like the prescaler
// - free-running: event on every period match, postscaled
// - single-shot: one event at match, postscaler ignored
// - up/down: event when timer reaches zero and turns up
// - double-update: events at zero and at period match
// - period is twelve bits from low nibble of high byte and low byte
// - period buffer copied at reset-after-match, at zero, or while disabled
// - free-running period lasts (period plus one) times prescale ticks
// - up/down period lasts twice period times prescale ticks
// - clearing enable holds the timer value
`timescale 1ns/1ps
`default_nettype none
`include "ptb_defines.svh"

module ptb_time_base
	import ptb_pkg::*;
#(
	parameter int TMR_W = 12
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst_b,
	input  wire logic [`PTB_ADDR_W-1:0] regAddr,
	input  wire logic [`PTB_DATA_W-1:0] regWrData,
	input  wire logic                   regWrStb,
	input  wire logic                   regRdStb,
	input  wire logic                   overrideWrite,
	output logic      [`PTB_DATA_W-1:0] regRdData,
	output logic      [TMR_W-1:0]       baseTimerValue,
	output logic                        countDirectionStatus,
	output logic                        periodMatchPulse,
	output logic                        zeroPulse,
	output logic                        bufferUpdatePulse,
	output logic                        compareGate,
	output logic                        overrideApply,
	output logic      [3:0]             triggerPostscaleSel,
	output logic                        triggerDirectionSel,
	output logic                        timebaseEventPulse,
	output logic                        timebaseIntFlag
);

	initial begin
		if (TMR_W != 12)
			$error("ptb_time_base: period registers serve a 12-bit timer only");
	end

	// reset release through two flops
	logic rstMeta_r;
	logic rstSync_r;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end
	wire logic rstN = rstSync_r;

	function automatic logic hit(input logic [`PTB_ADDR_W-1:0] idx);
		hit = regWrStb && (regAddr == idx);
	endfunction

	wire logic wrCtrl0  = hit(`PTB_IDX_CTRL0);
	wire logic wrCtrl1  = hit(`PTB_IDX_CTRL1);
	wire logic wrTrig   = hit(`PTB_IDX_TRIGUPD);
	wire logic wrTmrLo  = hit(`PTB_IDX_TMR_LO);
	wire logic wrTmrHi  = hit(`PTB_IDX_TMR_HI);
	wire logic wrPerLo  = hit(`PTB_IDX_PER_LO);
	wire logic wrPerHi  = hit(`PTB_IDX_PER_HI);
	wire logic wrInt    = hit(`PTB_IDX_INTSTAT);
	wire logic scaleClr = wrCtrl0 || wrCtrl1 || wrTmrLo || wrTmrHi;

	// control registers
	logic [`PTB_DATA_W-1:0] ctrl0_r;
	logic [`PTB_DATA_W-1:0] trig_r;
	logic                   enable_r;
	logic                   enable_nxt;

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			ctrl0_r <= `PTB_CTRL0_RESET;
		else if (wrCtrl0)
			ctrl0_r <= regWrData;
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			trig_r <= `PTB_TRIG_RESET;
		else if (wrTrig)
			trig_r <= regWrData & `PTB_TRIG_MASK;
	end

	ptb_mode_e mode;
	logic [1:0] preSel;
	logic [3:0] postSel;
	logic       updDisable;
	logic       overrideSync;
	assign mode         = ptb_mode_e'(ctrl0_r[`PTB_CTRL0_MODE_LO +: 2]);
	assign preSel       = ctrl0_r[`PTB_CTRL0_PRE_LO +: 2];
	assign postSel      = ctrl0_r[`PTB_CTRL0_POST_LO +: 4];
	assign updDisable   = trig_r[`PTB_TRIG_BUFFER_UPDATE_DISABLE_BIT];
	assign overrideSync = trig_r[`PTB_TRIG_SYNC_BIT];
	wire logic upDownMode = (mode == PTB_UPDOWN) || (mode == PTB_UPDOWN_DBL);

	// prescaler: terminal count 0, 3, 15 or 63
	logic [5:0] preCnt_r;
	logic [5:0] preTerm;
	always_comb begin
		case (preSel)
			2'h0: preTerm = 6'h00;
			2'h1: preTerm = 6'h03;
			2'h2: preTerm = 6'h0f;
			default: preTerm = 6'h3f;
		endcase
	end
	wire logic tick = enable_r && (preCnt_r >= preTerm);

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			preCnt_r <= 6'h00;
		else if (scaleClr || !enable_r || tick)
			preCnt_r <= 6'h00;
		else
			preCnt_r <= preCnt_r + 6'h01;
	end

	// period buffer and active period
	logic [TMR_W-1:0] perBuf_r;
	logic [TMR_W-1:0] period_r;
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			perBuf_r <= '0;
		else if (wrPerLo)
			perBuf_r[7:0] <= regWrData;
		else if (wrPerHi)
			perBuf_r[11:8] <= regWrData[3:0];
	end

	// timer core
	logic [TMR_W-1:0] tmr_r;
	logic             down_r;
	logic             matchEv;
	logic             zeroEv;
	logic             boundary;
	wire logic atPeriod = (tmr_r >= period_r);

	always_comb begin
		matchEv  = 1'b0;
		zeroEv   = 1'b0;
		boundary = 1'b0;
		if (tick) begin
			if (!upDownMode) begin
				matchEv  = atPeriod;
				boundary = atPeriod;
			end else if (!down_r) begin
				matchEv = atPeriod;
			end else if (tmr_r <= {{(TMR_W-1){1'b0}}, 1'b1}) begin
				zeroEv   = 1'b1;
				boundary = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			tmr_r  <= '0;
			down_r <= 1'b0;
		end else if (wrTmrLo) begin
			tmr_r[7:0] <= regWrData;
		end else if (wrTmrHi) begin
			tmr_r[11:8] <= regWrData[3:0];
		end else if (tick) begin
			if (!upDownMode) begin
				down_r <= 1'b0;
				if (atPeriod)
					tmr_r <= '0;
				else
					tmr_r <= tmr_r + 1'b1;
			end else if (!down_r) begin
				if (atPeriod && (period_r != '0)) begin
					down_r <= 1'b1;
					tmr_r  <= tmr_r - 1'b1;
				end else if (!atPeriod) begin
					tmr_r <= tmr_r + 1'b1;
				end
			end else begin
				tmr_r <= zeroEv ? '0 : tmr_r - 1'b1;
				if (zeroEv)
					down_r <= 1'b0;
			end
		end
	end

	wire logic loadPeriod = !updDisable && (boundary || !enable_r);
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			period_r <= '0;
		else if (loadPeriod)
			period_r <= perBuf_r;
	end

	// enable: hardware clears it after the single-shot match
	always_comb begin
		enable_nxt = enable_r;
		if (wrCtrl1)
			enable_nxt = regWrData[`PTB_CTRL1_EN_BIT];
		else if (matchEv && (mode == PTB_SINGLE))
			enable_nxt = 1'b0;
	end
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			enable_r <= 1'b0;
		else
			enable_r <= enable_nxt;
	end

	// compare gate held off until first down count in up/down modes
	logic gate_r;
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			gate_r <= 1'b0;
		else if (!upDownMode)
			gate_r <= 1'b1;
		else if (!enable_r)
			gate_r <= 1'b0;
		else if (down_r)
			gate_r <= 1'b1;
	end

	// postscaler on time-base events
	wire logic rawEv = zeroEv || (matchEv && (mode != PTB_UPDOWN));
	logic [3:0] postCnt_r;
	logic       postOut;
	assign postOut = rawEv && ((mode == PTB_SINGLE) || (postCnt_r == postSel));
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			postCnt_r <= 4'h0;
		else if (scaleClr)
			postCnt_r <= 4'h0;
		else if (rawEv && (mode != PTB_SINGLE))
			postCnt_r <= (postCnt_r == postSel) ? 4'h0 : postCnt_r + 4'h1;
	end

	// sticky flag, set wins over a clear in the same cycle
	logic intFlag_r;
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			intFlag_r <= 1'b0;
		else if (postOut)
			intFlag_r <= 1'b1;
		else if (wrInt && regWrData[`PTB_INT_FLAG_BIT])
			intFlag_r <= 1'b0;
	end

	// override apply: immediate or held to the next period boundary
	logic ovrPend_r;
	logic ovrApply_r;
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			ovrPend_r  <= 1'b0;
			ovrApply_r <= 1'b0;
		end else if (!overrideSync) begin
			ovrPend_r  <= 1'b0;
			ovrApply_r <= overrideWrite || ovrPend_r;
		end else begin
			ovrApply_r <= boundary && (ovrPend_r || overrideWrite);
			ovrPend_r  <= (ovrPend_r || overrideWrite) && !boundary;
		end
	end

	// registered event outputs
	logic matchOut_r;
	logic zeroOut_r;
	logic updOut_r;
	logic evOut_r;
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			matchOut_r <= 1'b0;
			zeroOut_r  <= 1'b0;
			updOut_r   <= 1'b0;
			evOut_r    <= 1'b0;
		end else begin
			matchOut_r <= matchEv;
			zeroOut_r  <= zeroEv;
			updOut_r   <= !updDisable && (boundary || (matchEv && mode == PTB_UPDOWN_DBL));
			evOut_r    <= postOut;
		end
	end

	// read port, data valid only in the cycle after the strobe
	logic [`PTB_DATA_W-1:0] rdData_r;
	logic [`PTB_DATA_W-1:0] rdMux;
	always_comb begin
		rdMux = 8'h00;
		if (regAddr == `PTB_IDX_CTRL0)
			rdMux = ctrl0_r;
		else if (regAddr == `PTB_IDX_CTRL1)
			rdMux = {enable_r, down_r, 6'h00};
		else if (regAddr == `PTB_IDX_TRIGUPD)
			rdMux = trig_r;
		else if (regAddr == `PTB_IDX_TMR_LO)
			rdMux = tmr_r[7:0];
		else if (regAddr == `PTB_IDX_TMR_HI)
			rdMux = {4'h0, tmr_r[11:8]};
		else if (regAddr == `PTB_IDX_PER_LO)
			rdMux = perBuf_r[7:0];
		else if (regAddr == `PTB_IDX_PER_HI)
			rdMux = {4'h0, perBuf_r[11:8]};
		else if (regAddr == `PTB_IDX_INTSTAT)
			rdMux = {7'h00, intFlag_r};
	end
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			rdData_r <= 8'h00;
		else
			rdData_r <= regRdStb ? rdMux : 8'h00;
	end

	assign regRdData            = rdData_r;
	assign baseTimerValue       = tmr_r;
	assign countDirectionStatus = down_r;
	assign periodMatchPulse     = matchOut_r;
	assign zeroPulse            = zeroOut_r;
	assign bufferUpdatePulse    = updOut_r;
	assign compareGate          = gate_r;
	assign overrideApply        = ovrApply_r;
	assign triggerPostscaleSel  = trig_r[`PTB_TRIG_POST_LO +: 4];
	assign triggerDirectionSel  = trig_r[`PTB_TRIG_DIR_BIT];
	assign timebaseEventPulse   = evOut_r;
	assign timebaseIntFlag      = intFlag_r;

endmodule
`default_nettype wire

// ==== testbench/ptb_time_base_checker.sv ====
// port assertions for the pwm time base
// assumes one sys_clk domain, bound to every ptb_time_base instance
`timescale 1ns/1ps
`default_nettype none
`include "ptb_defines.svh"
module ptb_time_base_checker #(
	parameter int TMR_W = 12
) (
	input wire logic             sys_clk,
	input wire logic             rst_b,
	input wire logic [3:0]       regAddr,
	input wire logic [7:0]       regWrData,
	input wire logic             regWrStb,
	input wire logic             regRdStb,
	input wire logic             overrideWrite,
	input wire logic [7:0]       regRdData,
	input wire logic [TMR_W-1:0] baseTimerValue,
	input wire logic             countDirectionStatus,
	input wire logic             periodMatchPulse,
	input wire logic             zeroPulse,
	input wire logic             bufferUpdatePulse,
	input wire logic             compareGate,
	input wire logic             overrideApply,
	input wire logic [3:0]       triggerPostscaleSel,
	input wire logic             triggerDirectionSel,
	input wire logic             timebaseEventPulse,
	input wire logic             timebaseIntFlag
);
	logic ovrSync_r;
	logic bufUpdDis_r;
	// shadow of the trigger/update control bits
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ovrSync_r   <= 1'b0;
			bufUpdDis_r <= 1'b0;
		end else if (regWrStb && regAddr == `PTB_IDX_TRIGUPD) begin
			ovrSync_r   <= regWrData[0];
			bufUpdDis_r <= regWrData[1];
		end
	end
	logic rstQ1_r;
	logic rstQ2_r;
	// reset release as the design sees it, two flops late
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstQ1_r <= 1'b0;
			rstQ2_r <= 1'b0;
		end else begin
			rstQ1_r <= 1'b1;
			rstQ2_r <= rstQ1_r;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstQ2_r);
	a_rd_idle_zero: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
		else $error("read data not zero outside a read");
	a_ctrl1_reserved: assert property (
		$past(regRdStb) && $past(regAddr) == `PTB_IDX_CTRL1 |-> regRdData[5:0] == 6'h00)
		else $error("control 1 reserved bits not zero");
	a_trig_fields: assert property (
		$past(regWrStb) && $past(regAddr) == `PTB_IDX_TRIGUPD
		|-> triggerPostscaleSel == $past(regWrData[7:4]) && triggerDirectionSel == $past(regWrData[3]))
		else $error("trigger fields not updated");
	a_flag_set: assert property (timebaseEventPulse |-> ##[0:1] timebaseIntFlag)
		else $error("event did not set flag");
	a_flag_clear: assert property ($fell(timebaseIntFlag) |-> $past(regWrStb)
		&& $past(regAddr) == `PTB_IDX_INTSTAT && $past(regWrData[0]))
		else $error("flag cleared without write");
	a_zero_turns_up: assert property (zeroPulse |-> !countDirectionStatus)
		else $error("direction not up at zero");
	a_event_source: assert property (
		timebaseEventPulse |-> periodMatchPulse || zeroPulse)
		else $error("event without match or zero");
	a_update_blocked: assert property (
		bufUpdDis_r && $past(bufUpdDis_r) |-> !bufferUpdatePulse)
		else $error("buffer update while disabled");
	a_ovr_async: assert property (overrideWrite && !ovrSync_r |=> overrideApply)
		else $error("async override not applied");
	a_tmr_load: assert property (
		$past(regWrStb) && $past(regAddr) == `PTB_IDX_TMR_LO
		|-> baseTimerValue[7:0] == $past(regWrData))
		else $error("timer write not taken");
	c_zero: cover property (zeroPulse);
	c_event_match: cover property (timebaseEventPulse && periodMatchPulse);
	c_ovr_sync: cover property (overrideApply && ovrSync_r);
endmodule
bind ptb_time_base ptb_time_base_checker #(.TMR_W(TMR_W)) i_chk (.sys_clk, .rst_b, .regAddr,
	.regWrData, .regWrStb, .regRdStb, .overrideWrite, .regRdData, .baseTimerValue,
	.countDirectionStatus, .periodMatchPulse, .zeroPulse, .bufferUpdatePulse, .compareGate,
	.overrideApply, .triggerPostscaleSel, .triggerDirectionSel, .timebaseEventPulse,
	.timebaseIntFlag);
`default_nettype wire

// ==== testbench/test_ptb_time_base.sv ====
// self-checking bench for the pwm time base
// assumes the design alone, driven through its register port
`timescale 1ns/1ps
`default_nettype none
`include "ptb_defines.svh"
module test_ptb_time_base import ptb_pkg::*; ;
	logic        sys_clk;
	logic        rst_b = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [7:0]  regWrData = 8'h00;
	logic        regWrStb = 1'b0;
	logic        regRdStb = 1'b0;
	logic        overrideWrite = 1'b0;
	logic [7:0]  regRdData;
	logic        periodMatchPulse;
	logic        zeroPulse;
	logic        compareGate;
	logic        timebaseEventPulse;
	logic [16:0] lfsr = 17'h14925;
	logic [7:0]  expQ[$];
	logic        rdPend = 1'b0;
	int          err_count = 0;
	int          checks = 0;
	int          cyc = 0;
	logic [3:0]  regIdx[4] = '{`PTB_IDX_CTRL0, `PTB_IDX_TRIGUPD, `PTB_IDX_PER_LO, `PTB_IDX_PER_HI};
	logic [7:0]  regMsk[4] = '{8'hff, 8'hfb, 8'hff, 8'h0f};

	ptb_time_base i_dut (.sys_clk, .rst_b, .regAddr, .regWrData, .regWrStb, .regRdStb,
		.overrideWrite, .regRdData, .baseTimerValue(), .countDirectionStatus(), .periodMatchPulse,
		.zeroPulse, .bufferUpdatePulse(), .compareGate, .overrideApply(), .triggerPostscaleSel(),
		.triggerDirectionSel(), .timebaseEventPulse, .timebaseIntFlag());

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	function automatic logic [16:0] lfsrNext(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction

	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic report_and_stop();
		if (err_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// one write or read, expected read data queued for the monitor
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		regAddr   <= a;
		regWrData <= d;
		regWrStb  <= w;
		regRdStb  <= !w;
		if (!w) expQ.push_back(d);
		@(posedge sys_clk);
		regWrStb <= 1'b0;
		regRdStb <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask

	// syncs to one pulse, then counts cycles to the next
	task automatic gap(input int sel, input int exp);
		int n;
		repeat (2) begin
			n = 0;
			do begin
				@(posedge sys_clk);
				#1;
				n++;
			end while (!(sel == 0 ? periodMatchPulse : sel == 1 ? zeroPulse
				: timebaseEventPulse) && n < 2000);
		end
		cmp("pulse spacing", exp[15:0], n[15:0]);
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		lfsr <= lfsrNext(lfsr);
		overrideWrite <= lfsr[0] & lfsr[3];
		if (rdPend) cmp("read data", {8'h00, expQ.pop_front()}, {8'h00, regRdData});
		rdPend <= regRdStb;
		if (cyc > 40000) begin
			err_count++;
			report_and_stop();
		end
	end

	initial begin
		logic [7:0] r;
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		for (int a = 0; a < 16; a++) acc(1'b0, a[3:0], 8'h00);
		foreach (regIdx[i]) begin
			r = lfsr[7:0];
			acc(1'b1, regIdx[i], r);
			acc(1'b0, regIdx[i], r & regMsk[i]);
		end
		acc(1'b1, 4'hc, 8'hff);
		acc(1'b0, 4'hc, 8'h00);
		acc(1'b1, `PTB_IDX_TMR_LO, 8'h5a);
		acc(1'b1, `PTB_IDX_CTRL1, 8'h00);
		repeat (20) @(posedge sys_clk);
		acc(1'b0, `PTB_IDX_TMR_LO, 8'h5a);
		acc(1'b1, `PTB_IDX_TRIGUPD, 8'h00);
		acc(1'b1, `PTB_IDX_PER_LO, 8'h02);
		acc(1'b1, `PTB_IDX_PER_HI, 8'h00);
		for (int p = 0; p < 4; p++) begin
			acc(1'b1, `PTB_IDX_CTRL0, {4'h0, p[1:0], PTB_FREE_RUN});
			acc(1'b1, `PTB_IDX_CTRL1, 8'h80);
			gap(0, 3 << (2 * p));
			acc(1'b1, `PTB_IDX_CTRL1, 8'h00);
		end
		acc(1'b1, `PTB_IDX_CTRL0, {4'h2, 2'h0, PTB_FREE_RUN});
		acc(1'b1, `PTB_IDX_CTRL1, 8'h80);
		gap(2, 9);
		acc(1'b1, `PTB_IDX_TRIGUPD, 8'h02);
		acc(1'b1, `PTB_IDX_PER_LO, 8'h05);
		gap(0, 3);
		acc(1'b1, `PTB_IDX_TRIGUPD, 8'h00);
		gap(0, 6);
		acc(1'b1, `PTB_IDX_CTRL1, 8'h00);
		acc(1'b0, `PTB_IDX_INTSTAT, 8'h01);
		acc(1'b1, `PTB_IDX_INTSTAT, 8'h01);
		acc(1'b0, `PTB_IDX_INTSTAT, 8'h00);
		acc(1'b1, `PTB_IDX_PER_LO, 8'h03);
		acc(1'b1, `PTB_IDX_TMR_LO, 8'h00);
		acc(1'b1, `PTB_IDX_CTRL0, {4'h0, 2'h0, PTB_UPDOWN});
		acc(1'b1, `PTB_IDX_CTRL1, 8'h80);
		cmp("compare gate", 16'h0000, {15'h0000, compareGate});
		gap(1, 6);
		cmp("compare gate", 16'h0001, {15'h0000, compareGate});
		gap(2, 6);
		acc(1'b1, `PTB_IDX_CTRL1, 8'h00);
		acc(1'b1, `PTB_IDX_CTRL0, {4'h0, 2'h0, PTB_UPDOWN_DBL});
		acc(1'b1, `PTB_IDX_TRIGUPD, 8'h01);
		acc(1'b1, `PTB_IDX_CTRL1, 8'h80);
		gap(1, 6);
		// match event follows, then zero event period minus one later
		gap(2, 2);
		acc(1'b1, `PTB_IDX_CTRL1, 8'h00);
		acc(1'b1, `PTB_IDX_TRIGUPD, 8'h00);
		acc(1'b1, `PTB_IDX_INTSTAT, 8'h01);
		acc(1'b1, `PTB_IDX_TMR_LO, 8'h00);
		acc(1'b1, `PTB_IDX_CTRL0, {4'hf, 2'h0, PTB_SINGLE});
		acc(1'b1, `PTB_IDX_CTRL1, 8'h80);
		repeat (8) @(posedge sys_clk);
		acc(1'b0, `PTB_IDX_CTRL1, 8'h00);
		acc(1'b0, `PTB_IDX_TMR_LO, 8'h00);
		acc(1'b0, `PTB_IDX_INTSTAT, 8'h01);
		repeat (3) @(posedge sys_clk);
		report_and_stop();
	end
endmodule
`default_nettype wire
